/* File: hdl/shared_regs_pkg.sv */
// Constants for the shared register bank and lane-space select decoding
package shared_regs_pkg;
   localparam int NUM_LANES = 4;
   localparam logic [7:0] ADDR_SPARE_A = 8'h02;
   localparam logic [7:0] ADDR_SPARE_B = 8'h03;
   localparam logic [7:0] ADDR_RST_LOAD = 8'h04;
   localparam logic [7:0] ADDR_LOAD_IRQ = 8'h05;
   localparam logic [7:0] ADDR_SPARE_C = 8'h06;
   localparam logic [7:0] ADDR_SPARE_D = 8'h07;
   localparam logic [7:0] ADDR_SELECT = 8'hFF;

   // Select register fields
   localparam int SEL_BCAST_BIT = 3;
   localparam int SEL_ENABLE_BIT = 2;
   localparam int SEL_LANE_MSB = 1;
   localparam int SEL_LANE_LSB = 0;

   // 0x04 fields
   localparam int RST_SOFT_BIT = 6;
   localparam int RST_MASTER_BIT = 5;
   localparam int RST_FORCE_BIT = 4;
   localparam logic [7:0] RST_STORE_MASK = 8'h9F;

   // 0x05 fields
   localparam int LD_DISABLE_BIT = 7;
   localparam int LD_DONE_BIT = 4;
   localparam logic [7:0] LD_WR_MASK = 8'hE0;

   // Reset values
   localparam logic [7:0] RST_SPARE_A = 8'h00;
   localparam logic [7:0] RST_SPARE_B = 8'h00;
   localparam logic [7:0] RST_RST_LOAD = 8'h01;
   localparam logic [7:0] RST_LOAD_HI = 8'h00;
   localparam logic RST_DONE = 1'b1;
   localparam logic [7:0] RST_SPARE_C = 8'h00;
   localparam logic [7:0] RST_SPARE_D = 8'h05;
   localparam logic [7:0] RST_SELECT = 8'h00;

   // Read of the select address and of unmapped shared addresses, and lane write strobe patterns
   localparam logic [7:0] SELECT_READ_JUNK = 8'hFF;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] ALL_LANES = 4'hF;
   localparam logic [3:0] LANE0_ONEHOT = 4'h1;
endpackage : shared_regs_pkg

/* File: hdl/shared_regs_channel_select.sv */
// Shared register bank with lane-space select decoding
`timescale 1ns/10ps
`default_nettype none
module shared_regs_channel_select (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [3:0][7:0] lane_rdata_i,
   input wire logic [3:0] lane_irq_i,
   input wire logic cfg_load_start_i,
   input wire logic cfg_load_done_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic [3:0] lane_wr_o,
   output logic [7:0] lane_addr_o,
   output logic [7:0] lane_wdata_o,
   output logic shared_soft_reset_o,
   output logic config_master_reset_o,
   output logic force_config_load_o,
   output logic config_load_disable_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] sel, next_sel;
   logic [7:0] spare_a, next_spare_a;
   logic [7:0] spare_b, next_spare_b;
   logic [7:0] rst_load, next_rst_load;
   logic [7:0] load_hi, next_load_hi;
   logic done, next_done;
   logic [3:0] irq, next_irq;
   logic [7:0] spare_c, next_spare_c;
   logic [7:0] spare_d, next_spare_d;
   logic [7:0] rdata, next_rdata;
   logic rvalid, next_rvalid;
   logic [3:0] lane_wr, next_lane_wr;
   logic [7:0] lane_addr, next_lane_addr;
   logic [7:0] lane_wdata, next_lane_wdata;
   logic soft_rst, next_soft_rst;
   logic mas_rst, next_mas_rst;
   logic [3:0] irq_view;
   logic [7:0] picked_lane_rd;
   logic lane_space;
   logic [1:0] tgt;

   // Lane 0 shows at the top bit
   genvar g;
   generate
      for (g = 0; g < shared_regs_pkg::NUM_LANES; g++) begin : g_irq
         assign irq_view[shared_regs_pkg::NUM_LANES - 1 - g] = lane_irq_i[g];
      end
   endgenerate

   assign lane_space = sel[shared_regs_pkg::SEL_ENABLE_BIT];
   assign tgt = sel[shared_regs_pkg::SEL_LANE_MSB:shared_regs_pkg::SEL_LANE_LSB];
   assign picked_lane_rd = lane_rdata_i[tgt];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_sel = sel;
      next_spare_a = spare_a;
      next_spare_b = spare_b;
      next_rst_load = rst_load;
      next_load_hi = load_hi;
      next_spare_c = spare_c;
      next_spare_d = spare_d;
      next_rdata = rdata;
      next_rvalid = 1'b0;
      next_lane_wr = 4'h0;
      next_lane_addr = lane_addr;
      next_lane_wdata = lane_wdata;
      next_soft_rst = 1'b0;
      next_mas_rst = 1'b0;
      next_irq = irq_view;
      next_done = done;
      // A completion in the same cycle as a new start wins
      if (cfg_load_start_i) begin
         next_done = 1'b0;
      end
      if (cfg_load_done_i) begin
         next_done = 1'b1;
      end
      if (wr_i) begin
         if (addr_i == shared_regs_pkg::ADDR_SELECT) begin
            next_sel = wdata_i;
         end else if (lane_space) begin
            next_lane_addr = addr_i;
            next_lane_wdata = wdata_i;
            if (sel[shared_regs_pkg::SEL_BCAST_BIT]) begin
               next_lane_wr = shared_regs_pkg::ALL_LANES;
            end else begin
               next_lane_wr = shared_regs_pkg::LANE0_ONEHOT << tgt;
            end
         end else begin
            case (addr_i)
               shared_regs_pkg::ADDR_SPARE_A: begin
                  next_spare_a = wdata_i;
               end
               shared_regs_pkg::ADDR_SPARE_B: begin
                  next_spare_b = wdata_i;
               end
               shared_regs_pkg::ADDR_RST_LOAD: begin
                  // Self-clearing bits are never stored
                  next_rst_load = wdata_i & shared_regs_pkg::RST_STORE_MASK;
                  next_mas_rst = wdata_i[shared_regs_pkg::RST_MASTER_BIT];
                  next_soft_rst = wdata_i[shared_regs_pkg::RST_SOFT_BIT];
               end
               shared_regs_pkg::ADDR_LOAD_IRQ: begin
                  // Done and lane flags are status only
                  next_load_hi = wdata_i & shared_regs_pkg::LD_WR_MASK;
               end
               shared_regs_pkg::ADDR_SPARE_C: begin
                  next_spare_c = wdata_i;
               end
               shared_regs_pkg::ADDR_SPARE_D: begin
                  next_spare_d = wdata_i;
               end
               default: begin
               end
            endcase
            if (next_soft_rst) begin
               // Select is kept so the host does not lose its bearings
               next_spare_a = shared_regs_pkg::RST_SPARE_A;
               next_spare_b = shared_regs_pkg::RST_SPARE_B;
               next_rst_load = shared_regs_pkg::RST_RST_LOAD;
               next_load_hi = shared_regs_pkg::RST_LOAD_HI;
               next_done = shared_regs_pkg::RST_DONE;
               next_spare_c = shared_regs_pkg::RST_SPARE_C;
               next_spare_d = shared_regs_pkg::RST_SPARE_D;
            end
         end
      end else if (rd_i) begin
         next_rvalid = 1'b1;
         if (addr_i == shared_regs_pkg::ADDR_SELECT) begin
            next_rdata = shared_regs_pkg::SELECT_READ_JUNK;
         end else if (lane_space) begin
            next_rdata = picked_lane_rd;
         end else begin
            case (addr_i)
               shared_regs_pkg::ADDR_SPARE_A: begin
                  next_rdata = spare_a;
               end
               shared_regs_pkg::ADDR_SPARE_B: begin
                  next_rdata = spare_b;
               end
               shared_regs_pkg::ADDR_RST_LOAD: begin
                  next_rdata = rst_load;
               end
               shared_regs_pkg::ADDR_LOAD_IRQ: begin
                  next_rdata = {load_hi[7:5], done, irq};
               end
               shared_regs_pkg::ADDR_SPARE_C: begin
                  next_rdata = spare_c;
               end
               shared_regs_pkg::ADDR_SPARE_D: begin
                  next_rdata = spare_d;
               end
               default: begin
                  next_rdata = shared_regs_pkg::UNMAPPED_READ;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel <= shared_regs_pkg::RST_SELECT;
         spare_a <= shared_regs_pkg::RST_SPARE_A;
         spare_b <= shared_regs_pkg::RST_SPARE_B;
         rst_load <= shared_regs_pkg::RST_RST_LOAD;
         load_hi <= shared_regs_pkg::RST_LOAD_HI;
         done <= shared_regs_pkg::RST_DONE;
         irq <= 4'h0;
         spare_c <= shared_regs_pkg::RST_SPARE_C;
         spare_d <= shared_regs_pkg::RST_SPARE_D;
         rdata <= 8'h00;
         rvalid <= 1'b0;
         lane_wr <= 4'h0;
         lane_addr <= 8'h00;
         lane_wdata <= 8'h00;
         soft_rst <= 1'b0;
         mas_rst <= 1'b0;
      end else begin
         sel <= next_sel;
         spare_a <= next_spare_a;
         spare_b <= next_spare_b;
         rst_load <= next_rst_load;
         load_hi <= next_load_hi;
         done <= next_done;
         irq <= next_irq;
         spare_c <= next_spare_c;
         spare_d <= next_spare_d;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         lane_wr <= next_lane_wr;
         lane_addr <= next_lane_addr;
         lane_wdata <= next_lane_wdata;
         soft_rst <= next_soft_rst;
         mas_rst <= next_mas_rst;
      end
   end

   assign rdata_o = rdata;
   assign rvalid_o = rvalid;
   assign lane_wr_o = lane_wr;
   assign lane_addr_o = lane_addr;
   assign lane_wdata_o = lane_wdata;
   assign shared_soft_reset_o = soft_rst;
   assign config_master_reset_o = mas_rst;
   assign force_config_load_o = rst_load[shared_regs_pkg::RST_FORCE_BIT];
   assign config_load_disable_o = load_hi[shared_regs_pkg::LD_DISABLE_BIT];

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   logic lane_wr_req;
   logic shared_wr_req;
   assign lane_wr_req = wr_i && addr_i != shared_regs_pkg::ADDR_SELECT && lane_space;
   assign shared_wr_req = wr_i && addr_i != shared_regs_pkg::ADDR_SELECT && !lane_space;

   a_bcast_all_lanes: assert property (
      lane_wr_req && sel[shared_regs_pkg::SEL_BCAST_BIT] |=> lane_wr_o == 4'hF
         && lane_wdata_o == $past(wdata_i))
      else $error("broadcast write missed a lane");

   a_lane_read_pick: assert property (
      rd_i && !wr_i && addr_i != shared_regs_pkg::ADDR_SELECT && lane_space
         |=> rvalid_o && rdata_o
         == $past(lane_rdata_i[sel[shared_regs_pkg::SEL_LANE_MSB:shared_regs_pkg::SEL_LANE_LSB]]))
      else $error("lane read from wrong lane");

   a_shared_no_lane: assert property (
      shared_wr_req |=> lane_wr_o == 4'h0)
      else $error("lane write while lane space off");

   a_select_write: assert property (
      wr_i && addr_i == shared_regs_pkg::ADDR_SELECT |=> sel == $past(wdata_i)
         && lane_wr_o == 4'h0)
      else $error("select write not taken");

   a_select_unread: assert property (
      rd_i && !wr_i && addr_i == shared_regs_pkg::ADDR_SELECT
         |=> rvalid_o && rdata_o == 8'hFF)
      else $error("select address read back stored value");

   a_single_lane: assert property (
      lane_wr_req && !sel[shared_regs_pkg::SEL_BCAST_BIT]
         |=> lane_wr_o == (4'h1 << $past(tgt)))
      else $error("single lane write hit wrong lanes");

   a_soft_reset_pulse: assert property (
      shared_wr_req && addr_i == 8'h04 && wdata_i[6]
         |=> shared_soft_reset_o && spare_d == 8'h05 && rst_load == 8'h01
         ##1 (!shared_soft_reset_o || $past(shared_wr_req && addr_i == 8'h04 && wdata_i[6])))
      else $error("soft reset did not restore or self-clear");

   a_master_reset_pulse: assert property (
      shared_wr_req && addr_i == 8'h04 && wdata_i[5] && !wdata_i[6]
         |=> config_master_reset_o && !rst_load[5]
         ##1 (!config_master_reset_o || $past(shared_wr_req && addr_i == 8'h04 && wdata_i[5])))
      else $error("master reset not a single pulse");

   a_force_load: assert property (
      shared_wr_req && addr_i == 8'h04 && !wdata_i[6]
         |=> force_config_load_o == $past(wdata_i[4]))
      else $error("force load not following write");

   a_load_disable: assert property (
      shared_wr_req && addr_i == 8'h05 |=> config_load_disable_o == $past(wdata_i[7]))
      else $error("load disable not following write");

   a_done_flag: assert property (
      cfg_load_done_i |=> done)
      else $error("done flag not set after load");

   a_irq_order: assert property (
      1'b1 |=> irq == {$past(lane_irq_i[0]), $past(lane_irq_i[1]),
         $past(lane_irq_i[2]), $past(lane_irq_i[3])})
      else $error("lane interrupt bits out of order");

   a_select_holds: assert property (
      !(wr_i && addr_i == shared_regs_pkg::ADDR_SELECT) |=> $stable(sel))
      else $error("select changed without a write");

   a_ro_ignored: assert property (
      shared_wr_req && addr_i == 8'h05 && !cfg_load_start_i && !cfg_load_done_i
         |=> done == $past(done) && irq == $past(irq_view))
      else $error("read-only bits took a write");

   a_spare_keep: assert property (
      shared_wr_req && addr_i == 8'h02 |=> spare_a == $past(wdata_i) && lane_wr_o == 4'h0
         && $stable(force_config_load_o) && $stable(config_load_disable_o))
      else $error("reserved location lost its value");

   c_broadcast: cover property (lane_wr_o == 4'hF);
   c_lane_read: cover property (rd_i && lane_space ##1 rvalid_o);
   c_soft_reset: cover property (shared_soft_reset_o);
   c_load_done: cover property (cfg_load_start_i ##[1:20] cfg_load_done_i);

endmodule : shared_regs_channel_select
`default_nettype wire

/* File: verif/lane_sets_model.sv */
// Behavioural model of the four lane register sets behind the select decoder
`timescale 1ns/10ps
`default_nettype none
module lane_sets_model (
   input wire logic mclk_i,
   input wire logic [3:0] lane_wr_i,
   input wire logic [7:0] lane_addr_i,
   input wire logic [7:0] lane_wdata_i,
   input wire logic [7:0] rd_addr_i,
   output logic [3:0][7:0] lane_rdata_o
);
   logic [7:0] mem [4][256];

   // Each set takes its own strobe, so a broadcast lands in all four
   always_ff @(posedge mclk_i) begin
      for (int g = 0; g < 4; g++) begin
         if (lane_wr_i[g]) begin
            mem[g][lane_addr_i] <= lane_wdata_i;
         end
      end
   end

   // Read data is combinational on the request address, as the decoder expects
   always_comb begin
      for (int g = 0; g < 4; g++) begin
         lane_rdata_o[g] = mem[g][rd_addr_i];
      end
   end
endmodule : lane_sets_model
`default_nettype wire

/* File: verif/shared_regs_channel_select_bench.sv */
// Self-checking bench for the shared register bank and lane select
`timescale 1ns/10ps
`default_nettype none
module shared_regs_channel_select_bench;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [3:0] lane_irq_i = 4'h0;
   logic ld_start = 1'b0;
   logic ld_done = 1'b0;
   logic [3:0][7:0] lane_rdata;
   logic [7:0] rdata_o;
   logic [7:0] lane_addr_o;
   logic [7:0] lane_wdata_o;
   logic [3:0] lane_wr_o;
   logic rvalid_o;
   logic soft_rst;
   logic mas_rst;
   logic force_ld;
   logic ld_dis;
   int mismatches = 0;
   int tests_run = 0;

   shared_regs_channel_select dut_u (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .lane_rdata_i(lane_rdata),
      .lane_irq_i(lane_irq_i), .cfg_load_start_i(ld_start),
      .cfg_load_done_i(ld_done), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .lane_wr_o(lane_wr_o), .lane_addr_o(lane_addr_o),
      .lane_wdata_o(lane_wdata_o), .shared_soft_reset_o(soft_rst),
      .config_master_reset_o(mas_rst), .force_config_load_o(force_ld),
      .config_load_disable_o(ld_dis)
   );

   lane_sets_model lanes_u (
      .mclk_i(mclk_i), .lane_wr_i(lane_wr_o), .lane_addr_i(lane_addr_o),
      .lane_wdata_i(lane_wdata_o), .rd_addr_i(addr_i), .lane_rdata_o(lane_rdata)
   );

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Registered answers are looked at one negedge after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      wr_i = 1'b1;
      addr_i = a;
      wdata_i = d;
      @(negedge mclk_i);
      wr_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk_i);
      rd_i = 1'b1;
      addr_i = a;
      @(negedge mclk_i);
      rd_i = 1'b0;
      chk({7'h00, rvalid_o}, 8'h01);
      chk(rdata_o, exp);
   endtask : rd

   task automatic load_evt(input logic st, input logic dn);
      @(negedge mclk_i);
      ld_start = st;
      ld_done = dn;
      @(negedge mclk_i);
      ld_start = 1'b0;
      ld_done = 1'b0;
   endtask : load_evt

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge mclk_i);
      nrst_i = 1'b1;
      rd(8'h02, 8'h00);
      rd(8'h04, 8'h01);
      rd(8'h05, 8'h10);
      rd(8'h07, 8'h05);
      rd(8'hff, 8'hff);
      wr(8'h05, 8'hff);
      rd(8'h05, 8'hf0);
      chk({7'h00, ld_dis}, 8'h01);
      wr(8'h04, 8'h10);
      chk({7'h00, force_ld}, 8'h01);
      wr(8'h04, 8'h20);
      chk({7'h00, mas_rst}, 8'h01);
      rd(8'h04, 8'h00);
      chk({7'h00, mas_rst}, 8'h00);
      wr(8'h02, 8'ha5);
      rd(8'h02, 8'ha5);
      wr(8'h04, 8'h40);
      chk({7'h00, soft_rst}, 8'h01);
      rd(8'h02, 8'h00);
      chk({7'h00, soft_rst}, 8'h00);
      rd(8'h04, 8'h01);
      rd(8'h05, 8'h10);
      lane_irq_i = 4'h1;
      rd(8'h05, 8'h18);
      lane_irq_i = 4'h8;
      rd(8'h05, 8'h11);
      lane_irq_i = 4'h0;
      load_evt(1'b1, 1'b0);
      rd(8'h05, 8'h00);
      load_evt(1'b1, 1'b1);
      rd(8'h05, 8'h10);
      // Upper nibble of every select write stays zero
      for (int g = 0; g < 4; g++) begin
         wr(8'hff, 8'h04 + 8'(g));
         wr(8'h10, 8'h40 + 8'(g));
         chk({4'h0, lane_wr_o}, 8'h01 << g);
      end
      wr(8'hff, 8'h0c);
      wr(8'h20, 8'h99);
      chk({4'h0, lane_wr_o}, 8'h0f);
      chk(lane_wdata_o, 8'h99);
      chk(lane_addr_o, 8'h20);
      for (int g = 0; g < 4; g++) begin
         wr(8'hff, 8'h0c + 8'(g));
         rd(8'h10, 8'h40 + 8'(g));
         rd(8'h20, 8'h99);
      end
      wr(8'hff, 8'h05);
      chk({4'h0, lane_wr_o}, 8'h00);
      rd(8'hff, 8'hff);
      rd(8'h10, 8'h41);
      wr(8'hff, 8'h08);
      wr(8'h02, 8'h3c);
      chk({4'h0, lane_wr_o}, 8'h00);
      rd(8'h02, 8'h3c);
      rd(8'h10, 8'h00);
      // Read beside a write is dropped, the write still lands
      @(negedge mclk_i);
      wr_i = 1'b1;
      rd_i = 1'b1;
      addr_i = 8'h03;
      wdata_i = 8'h5a;
      @(negedge mclk_i);
      wr_i = 1'b0;
      rd_i = 1'b0;
      chk({7'h00, rvalid_o}, 8'h00);
      rd(8'h03, 8'h5a);
      end_sim();
   end

   // Hang guard
   initial begin
      repeat (5000) @(posedge mclk_i);
      mismatches++;
      end_sim();
   end
endmodule : shared_regs_channel_select_bench
`default_nettype wire
